/* File: src/pic_pkg.sv */
// Package: register map, source tables and carriers of the interrupt controller
package pic_pkg;
	localparam int NUM_SRC = 29;
	localparam int NUM_INT = 23;
	localparam int NUM_REG = 6;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [5:0] IDX_PRIO_A = 6'h00;
	localparam logic [5:0] IDX_PRIO_F = 6'h05;
	localparam logic [5:0] IDX_XFER_A = 6'h08;
	localparam logic [5:0] IDX_XFER_F = 6'h0D;
	localparam logic [5:0] IDX_SYS_ONE = 6'h10;
	localparam logic [5:0] IDX_SYS_TWO = 6'h11;
	localparam logic [5:0] IDX_STATUS = 6'h12;

	// Field positions and write masks
	localparam int BIT_NMI_EDGE = 4;
	localparam int BIT_REQ0_EN = 5;
	localparam int BIT_REQ1_EN = 6;
	localparam logic [7:0] SYS_ONE_MASK = 8'h70;
	localparam logic [7:0] SYS_TWO_MASK = 8'h0F;
	localparam logic [7:0] PRIO_MASK = 8'h77;
	localparam logic [7:0] PRIO_RSVD = 8'h88;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Source slots: table order is also the tie order on equal levels
	localparam logic [4:0] SRC_REQ0 = 5'h00;
	localparam logic [4:0] SRC_REQ1 = 5'h02;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Minimum-mode vector byte address per source; maximum mode doubles it
	localparam logic [7:0] VEC_MIN [NUM_SRC] = '{
		8'h40, 8'h42, 8'h48, 8'h50, 8'h52, 8'h58, 8'h5A,
		8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E,
		8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h7A, 8'h7C,
		8'h80, 8'h82, 8'h84, 8'h88, 8'h8A, 8'h8C, 8'h90};

	// Priority field per source: {register index, lower half}
	localparam logic [3:0] PRIO_FIELD [NUM_SRC] = '{
		4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3,
		4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h5,
		4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
		4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'hA};

	// Transfer-enable bit per source: {exists, register index, bit}
	localparam logic [6:0] DTE_SEL [NUM_SRC] = '{
		7'h44, 7'h45, 7'h40, 7'h4C, 7'h4D, 7'h48, 7'h49,
		7'h50, 7'h51, 7'h52, 7'h00, 7'h54, 7'h55, 7'h56, 7'h00,
		7'h58, 7'h59, 7'h5A, 7'h00, 7'h5C, 7'h5D, 7'h00,
		7'h00, 7'h61, 7'h62, 7'h00, 7'h65, 7'h66, 7'h6C};

	typedef enum {ST_IDLE, ST_REQ, ST_SETTLE1, ST_SETTLE2} pic_state_t;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} pic_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pic_axi_resp_t;

	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic [8:0] vector;
		logic [4:0] source;
	} pic_svc_t;
endpackage : pic_pkg

/* File: src/pic_pin_sync.sv */
// Two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ps
`default_nettype none
module pic_pin_sync (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic pinIn,
	output logic level,
	output logic fall,
	output logic rise
);
	logic meta;
	logic stable;
	logic prev;

	// Idle level is high; the first stage is never looked at
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta <= 1'b1;
			stable <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= pinIn;
			stable <= meta;
			prev <= stable;
		end
	end

	assign level = stable;
	assign fall = prev & ~stable;
	assign rise = ~prev & stable;
endmodule : pic_pin_sync
`default_nettype wire

/* File: src/pic_controller.sv */
// Prioritised interrupt controller with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: low request-zero pin counts only when enabled
// R2: source holds request-zero low until accepted
// R3: request zero level from priority A upper
// R4: transfer A bit 4 routes request zero
// R5: CPU service clears trace, loads mask level
// R6: requests one to five sense falling edges
// R7: request one to five individual enable bits
// R8: request one to five share A/B fields
// R9: edge latches clear when their service runs
// R10: repeat during handler stays pending until unmasked
// R11: transfer A/B bits route requests one-five
// R12: twenty-three internal requests, own vectors each
// R13: modules gate internal requests with enables
// R14: one level per module for all requests
// R15: fixed rank inside each module
// R16: internal requests unlatched; software clears source
// R17: level first, then fixed source order
// R18: transfer C-F bits route internal sources, transfer A bit 5 the first one
// R19: reset clears all priority registers
// R20: two-byte or four-byte vector per source
// R21: edge select bit picks nonmask edge
// R22: forward only if level exceeds mask
// R23: priority bits 7 and 3 read zero
// R24: hold level and vector until acknowledged
module pic_controller (
	input wire logic core_clk,
	input wire logic nrst,
	input wire pic_pkg::pic_axi_req_t axiIn,
	output pic_pkg::pic_axi_resp_t axiOut,
	input wire logic extReqZeroN,
	input wire logic [4:0] extReqN,
	input wire logic nonmaskPin,
	input wire logic [22:0] intReq,
	input wire logic [2:0] cpuMaskLevel,
	input wire logic maxModeSel,
	input wire logic cpuAck,
	input wire logic dtcAck,
	input wire logic nmiAck,
	output pic_pkg::pic_svc_t cpuOut,
	output pic_pkg::pic_svc_t dtcOut,
	output logic nonmaskReq,
	output logic maskLoad,
	output logic [2:0] maskValue,
	output logic traceClear
);
	logic [7:0] prio [pic_pkg::NUM_REG];
	logic [7:0] xferEn [pic_pkg::NUM_REG];
	logic [7:0] sysOne;
	logic [7:0] sysTwo;
	logic [4:0] extLatch;
	logic [4:0] latchSet;
	logic [4:0] latchClr;
	logic [6:0] pinAll;
	logic [6:0] levelAll;
	logic [6:0] fallAll;
	logic [6:0] riseAll;
	logic req0Level;
	logic [pic_pkg::NUM_SRC-1:0] srcReq;
	logic [pic_pkg::NUM_SRC-1:0] srcToDtc;
	logic [2:0] srcLevel [pic_pkg::NUM_SRC];
	logic [2:0] bestLevel;
	logic [4:0] bestIdx;
	logic bestValid;
	logic winValidQ;
	logic [2:0] winLevelQ;
	logic [4:0] winIdxQ;
	logic accept;
	logic ackTaken;
	logic reqToDtc;
	logic [8:0] next_vector;
	logic nmiEdge;
	pic_pkg::pic_state_t state;
	logic awHeld;
	logic wHeld;
	logic [7:0] awAddrQ;
	logic [7:0] wDataQ;
	logic wLaneQ;
	logic doWrite;
	logic [5:0] wrIdx;
	logic [5:0] rdIdx;
	logic wrHit;
	logic rdHit;
	logic [7:0] rdByte;

	////////////////////////////////////////////////////////////////////////////////
	// Pin conditioning: bit 0 request zero, bits 1-5 requests one-five, bit 6 nonmask
	assign pinAll = {nonmaskPin, extReqN, extReqZeroN};
	for (genvar p = 0; p < 7; p++) begin : gPin
		pic_pin_sync uSync (
			.core_clk(core_clk),
			.nrst(nrst),
			.pinIn(pinAll[p]),
			.level(levelAll[p]),
			.fall(fallAll[p]),
			.rise(riseAll[p])
		);
	end

	// Level request; a pin released before acceptance simply drops out
	assign req0Level = ~levelAll[0] & sysOne[pic_pkg::BIT_REQ0_EN]; // R1 R2

	// Edge latches; a new edge beats a clear in the same cycle
	assign latchSet = fallAll[5:1] & {sysTwo[3:0], sysOne[pic_pkg::BIT_REQ1_EN]}; // R6 R7
	for (genvar k = 0; k < 5; k++) begin : gClr
		localparam logic [4:0] SLOT = pic_pkg::SRC_REQ1 + 5'(k);
		assign latchClr[k] = ackTaken && (state == pic_pkg::ST_REQ)
			&& ((cpuOut.req ? cpuOut.source : dtcOut.source) == SLOT); // R9
	end

	// Nonmask edge, held until the CPU takes it
	assign nmiEdge = sysOne[pic_pkg::BIT_NMI_EDGE] ? riseAll[6] : fallAll[6]; // R21

	// Latched events; a set in the clearing cycle wins so no edge is lost
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			extLatch <= 5'h00;
			nonmaskReq <= 1'b0;
		end else begin
			extLatch <= (extLatch & ~latchClr) | latchSet; // R9 R10
			nonmaskReq <= (nonmaskReq & ~nmiAck) | nmiEdge; // R21
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Source vector in tie order; internal lines are levels, never latched here
	assign srcReq = {intReq[22:1], extLatch, intReq[0], req0Level}; // R12 R13 R16

	// Per-source level and route lookup
	for (genvar g = 0; g < pic_pkg::NUM_SRC; g++) begin : gSrc
		localparam logic [3:0] FLD = pic_pkg::PRIO_FIELD[g];
		localparam logic [6:0] DTE = pic_pkg::DTE_SEL[g];
		assign srcLevel[g] = FLD[0] ? prio[FLD[3:1]][2:0] : prio[FLD[3:1]][6:4]; // R3 R8 R14
		assign srcToDtc[g] = DTE[6] & xferEn[DTE[5:3]][DTE[2:0]]; // R4 R11 R18
	end

	// Highest level wins; strict compare keeps the lowest slot on ties
	always_comb begin
		bestLevel = 3'h0;
		bestIdx = 5'h00;
		bestValid = 1'b0;
		for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
			if (srcReq[i] && srcLevel[i] > bestLevel) begin // R15 R17
				bestLevel = srcLevel[i];
				bestIdx = 5'(i);
				bestValid = 1'b1;
			end
		end
	end

	// Registered winner: the decision takes two clocks from request to strobe
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			winValidQ <= 1'b0;
			winLevelQ <= 3'h0;
			winIdxQ <= 5'h00;
		end else begin
			winValidQ <= bestValid;
			winLevelQ <= bestLevel;
			winIdxQ <= bestIdx;
		end
	end

	// Stale winners are dropped if the source has since withdrawn
	assign accept = (state == pic_pkg::ST_IDLE) && winValidQ && srcReq[winIdxQ]
		&& (winLevelQ > cpuMaskLevel); // R22
	assign reqToDtc = srcToDtc[winIdxQ];
	assign next_vector = maxModeSel ? {pic_pkg::VEC_MIN[winIdxQ], 1'b0}
		: {1'b0, pic_pkg::VEC_MIN[winIdxQ]}; // R20
	assign ackTaken = (cpuOut.req && cpuAck) || (dtcOut.req && dtcAck);

	////////////////////////////////////////////////////////////////////////////////
	// Service handshake; settle states let the CPU load its mask first
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= pic_pkg::ST_IDLE;
			cpuOut <= '0;
			dtcOut <= '0;
			maskLoad <= 1'b0;
			maskValue <= 3'h0;
			traceClear <= 1'b0;
		end else begin
			maskLoad <= 1'b0;
			traceClear <= 1'b0;
			case (state)
				pic_pkg::ST_IDLE: begin
					if (accept) begin
						state <= pic_pkg::ST_REQ;
						if (reqToDtc) begin
							dtcOut <= '{1'b1, winLevelQ, next_vector, winIdxQ}; // R4 R11 R18
						end else begin
							cpuOut <= '{1'b1, winLevelQ, next_vector, winIdxQ}; // R24
						end
					end
				end
				pic_pkg::ST_REQ: begin
					if (ackTaken) begin
						state <= pic_pkg::ST_SETTLE1;
						cpuOut.req <= 1'b0;
						dtcOut.req <= 1'b0;
						if (cpuOut.req) begin
							maskLoad <= 1'b1; // R5
							maskValue <= cpuOut.level; // R5
							traceClear <= 1'b1; // R5
						end
					end
				end
				pic_pkg::ST_SETTLE1: begin
					state <= pic_pkg::ST_SETTLE2;
				end
				default: begin
					state <= pic_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in any order
	assign doWrite = awHeld && wHeld && !axiOut.bvalid;
	assign wrIdx = awAddrQ[7:2];
	assign wrHit = (wrIdx <= pic_pkg::IDX_PRIO_F) || (wrIdx == pic_pkg::IDX_STATUS)
		|| (wrIdx >= pic_pkg::IDX_XFER_A && wrIdx <= pic_pkg::IDX_XFER_F)
		|| (wrIdx == pic_pkg::IDX_SYS_ONE) || (wrIdx == pic_pkg::IDX_SYS_TWO);

	// Read decode; unmapped words answer SLVERR with zero data
	assign rdIdx = axiIn.araddr[7:2];
	always_comb begin
		rdHit = 1'b1;
		if (rdIdx <= pic_pkg::IDX_PRIO_F) begin
			rdByte = prio[rdIdx[2:0]];
		end else if (rdIdx >= pic_pkg::IDX_XFER_A && rdIdx <= pic_pkg::IDX_XFER_F) begin
			rdByte = xferEn[3'(rdIdx - pic_pkg::IDX_XFER_A)];
		end else if (rdIdx == pic_pkg::IDX_SYS_ONE) begin
			rdByte = sysOne;
		end else if (rdIdx == pic_pkg::IDX_SYS_TWO) begin
			rdByte = sysTwo;
		end else if (rdIdx == pic_pkg::IDX_STATUS) begin
			rdByte = {nonmaskReq, 2'h0, extLatch};
		end else begin
			rdByte = 8'h00;
			rdHit = 1'b0;
		end
	end

	// Bus handshake; ready drops after a take and returns once the answer is taken
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			axiOut <= '{1'b1, 1'b1, 1'b0, pic_pkg::RESP_OKAY, 1'b1, 1'b0, 32'h00000000,
				pic_pkg::RESP_OKAY};
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 8'h00;
			wDataQ <= 8'h00;
			wLaneQ <= 1'b0;
		end else begin
			if (axiOut.awready && axiIn.awvalid) begin
				awHeld <= 1'b1;
				awAddrQ <= axiIn.awaddr;
				axiOut.awready <= 1'b0;
			end
			if (axiOut.wready && axiIn.wvalid) begin
				wHeld <= 1'b1;
				wDataQ <= axiIn.wdata[7:0];
				wLaneQ <= axiIn.wstrb[0];
				axiOut.wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				axiOut.bvalid <= 1'b1;
				axiOut.bresp <= wrHit ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
			end
			if (axiOut.bvalid && axiIn.bready) begin
				axiOut.bvalid <= 1'b0;
				axiOut.awready <= 1'b1;
				axiOut.wready <= 1'b1;
			end
			if (axiOut.arready && axiIn.arvalid) begin
				axiOut.arready <= 1'b0;
				axiOut.rvalid <= 1'b1;
				axiOut.rdata <= {24'h000000, rdByte};
				axiOut.rresp <= rdHit ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
			end
			if (axiOut.rvalid && axiIn.rready) begin
				axiOut.rvalid <= 1'b0;
				axiOut.arready <= 1'b1;
			end
		end
	end

	// Register file; reset leaves every maskable source at level zero
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int r = 0; r < pic_pkg::NUM_REG; r++) begin
				prio[r] <= pic_pkg::REG_RESET; // R19
				xferEn[r] <= pic_pkg::REG_RESET;
			end
			sysOne <= pic_pkg::REG_RESET;
			sysTwo <= pic_pkg::REG_RESET;
		end else if (doWrite && wLaneQ) begin
			if (wrIdx <= pic_pkg::IDX_PRIO_F) begin
				prio[wrIdx[2:0]] <= wDataQ & pic_pkg::PRIO_MASK; // R23
			end else if (wrIdx >= pic_pkg::IDX_XFER_A && wrIdx <= pic_pkg::IDX_XFER_F) begin
				xferEn[3'(wrIdx - pic_pkg::IDX_XFER_A)] <= wDataQ;
			end else if (wrIdx == pic_pkg::IDX_SYS_ONE) begin
				sysOne <= wDataQ & pic_pkg::SYS_ONE_MASK;
			end else if (wrIdx == pic_pkg::IDX_SYS_TWO) begin
				sysTwo <= wDataQ & pic_pkg::SYS_TWO_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the design's own outputs and state
	default clocking cbMain @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	AST_REQ0_GATED: assert property ( // R1
		!sysOne[pic_pkg::BIT_REQ0_EN] [*3] |-> !(winValidQ && winIdxQ == pic_pkg::SRC_REQ0))
		else $error("request zero won while disabled");
	AST_EDGE_ONLY: assert property ( // R6
		(|(extLatch & ~$past(extLatch))) |-> $past(|fallAll[5:1]))
		else $error("edge latch set without falling edge");
	AST_REQ1_ENABLE: assert property ( // R7
		$rose(extLatch[0]) |-> $past(sysOne[pic_pkg::BIT_REQ1_EN]))
		else $error("request one latched while disabled");
	AST_LATCH_CLEAR: assert property ( // R9
		(ackTaken && state == pic_pkg::ST_REQ && !latchSet[0]
		&& (cpuOut.req ? cpuOut.source : dtcOut.source) == pic_pkg::SRC_REQ1) |=> !extLatch[0])
		else $error("request one latch not cleared by service");
	AST_MASK_STRICT: assert property ( // R22
		$rose(cpuOut.req) |-> cpuOut.level > $past(cpuMaskLevel))
		else $error("request forwarded at or below mask");
	AST_MASK_LOAD: assert property ( // R5
		(state == pic_pkg::ST_REQ && cpuOut.req && cpuAck)
		|=> maskLoad && traceClear && maskValue == $past(cpuOut.level))
		else $error("mask not loaded with serviced level");
	AST_HOLD_STABLE: assert property ( // R24
		(cpuOut.req && !cpuAck) |=> cpuOut.req && $stable(cpuOut.vector) && $stable(cpuOut.level))
		else $error("request changed before acknowledge");
	AST_DTC_ROUTE: assert property ( // R4
		($rose(dtcOut.req) && dtcOut.source == pic_pkg::SRC_REQ0) |-> $past(xferEn[0][4]))
		else $error("request zero sent to transfer unit while not enabled");
	AST_VECTOR_ZERO: assert property ( // R20
		($rose(cpuOut.req) && cpuOut.source == pic_pkg::SRC_REQ0)
		|-> cpuOut.vector == ($past(maxModeSel) ? 9'h080 : 9'h040))
		else $error("wrong vector for request zero");
	AST_RESERVED: assert property ( // R23
		((prio[0] | prio[1] | prio[2] | prio[3] | prio[4] | prio[5]) & pic_pkg::PRIO_RSVD) == 8'h00)
		else $error("reserved priority bit set");
	AST_NMI_EDGE: assert property ( // R21
		$rose(nonmaskReq) |-> $past(sysOne[pic_pkg::BIT_NMI_EDGE] ? riseAll[6] : fallAll[6]))
		else $error("nonmask request without selected edge");

	COV_CPU_SERVICE: cover property ($rose(cpuOut.req) ##[1:20] cpuAck);
	COV_DTC_SERVICE: cover property ($rose(dtcOut.req) ##[1:20] dtcAck);
	COV_REPEAT_PENDING: cover property (latchSet[0] && latchClr[0]);
	COV_NMI: cover property ($rose(nonmaskReq));
endmodule : pic_controller
`default_nettype wire

/* File: verif/pic_cpu_model.sv */
// Behavioural CPU core and transfer unit answering the service strobes
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire pic_pkg::pic_svc_t cpuOut,
	input wire pic_pkg::pic_svc_t dtcOut,
	input wire logic nonmaskReq,
	input wire logic maskLoad,
	input wire logic [2:0] maskValue,
	input wire logic slow,
	input wire logic maskSet,
	input wire logic [2:0] maskIn,
	output logic cpuAck,
	output logic dtcAck,
	output logic nmiAck,
	output logic [2:0] cpuMaskLevel,
	output pic_pkg::pic_svc_t lastSvc,
	output logic lastDtc,
	output logic [7:0] svcCount,
	output logic [7:0] nmiCount
);
	logic [2:0] waitCnt;
	// Slow mode waits four cycles so held outputs are exercised
	wire logic anyReq = cpuOut.req | dtcOut.req;
	wire logic ackNow = anyReq & ~cpuAck & ~dtcAck & (~slow | (waitCnt == 3'h4));

	////////////////////////////////////////////////////////////
	// One-cycle acks; capture of what was taken at the ack edge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			{cpuAck, dtcAck, nmiAck, lastDtc, waitCnt, svcCount, nmiCount} <= '0;
			cpuMaskLevel <= 3'h0;
			lastSvc <= '0;
		end else begin
			waitCnt <= (anyReq && !ackNow) ? waitCnt + 3'h1 : 3'h0;
			cpuAck <= ackNow & cpuOut.req;
			dtcAck <= ackNow & dtcOut.req & ~cpuOut.req;
			nmiAck <= nonmaskReq & ~nmiAck;
			if (nmiAck) begin
				nmiCount <= nmiCount + 8'h01;
			end
			if (cpuAck | dtcAck) begin
				lastSvc <= cpuAck ? cpuOut : dtcOut;
				lastDtc <= dtcAck;
				svcCount <= svcCount + 8'h01;
			end
			// Software write wins over the service load
			if (maskSet) begin
				cpuMaskLevel <= maskIn;
			end else if (maskLoad) begin
				cpuMaskLevel <= maskValue;
			end
		end
	end
endmodule : pic_cpu_model
`default_nettype wire

/* File: verif/prioritized_interrupt_controller_tb_top.sv */
// Self-checking bench: registers, pins, internal requests, service order
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb_top;
	logic core_clk, nrst, extReqZeroN, nonmaskPin, maxModeSel, slow, maskSet;
	logic cpuAck, dtcAck, nmiAck, nonmaskReq, maskLoad, traceClear, lastDtc;
	logic [4:0] extReqN;
	logic [22:0] intReq;
	logic [2:0] maskIn, cpuMaskLevel, maskValue, l, m;
	logic [7:0] svcCount, nmiCount, seenCnt;
	logic [1:0] rsp;
	logic [31:0] rdw;
	pic_pkg::pic_axi_req_t axiIn;
	pic_pkg::pic_axi_resp_t axiOut;
	pic_pkg::pic_svc_t cpuOut, dtcOut, lastSvc;
	int fails, samples_checked, seed, i;
	// Minimum-mode vector per source slot, slots in tie order
	localparam logic [7:0] VT [29] = '{8'h40, 8'h42, 8'h48, 8'h50, 8'h52, 8'h58, 8'h5A,
		8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E,
		8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h7A, 8'h7C,
		8'h80, 8'h82, 8'h84, 8'h88, 8'h8A, 8'h8C, 8'h90};
	// Simultaneous request sets, winner slot and level
	localparam logic [22:0] TQ [4] = '{23'h000012, 23'h070000, 23'h400200, 23'h0C0000};
	localparam logic [4:0] TS [4] = '{5'h07, 5'h16, 5'h1C, 5'h18};
	localparam logic [2:0] TL [4] = '{3'h3, 3'h3, 3'h5, 3'h3};

	pic_controller i_dut (.core_clk, .nrst, .axiIn, .axiOut, .extReqZeroN, .extReqN,
		.nonmaskPin, .intReq, .cpuMaskLevel, .maxModeSel, .cpuAck, .dtcAck, .nmiAck,
		.cpuOut, .dtcOut, .nonmaskReq, .maskLoad, .maskValue, .traceClear);
	pic_cpu_model i_cpu (.core_clk, .nrst, .cpuOut, .dtcOut, .nonmaskReq, .maskLoad,
		.maskValue, .slow, .maskSet, .maskIn, .cpuAck, .dtcAck, .nmiAck, .cpuMaskLevel,
		.lastSvc, .lastDtc, .svcCount, .nmiCount);

	// 10 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			fails++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 60) begin
			chk("wait bound", 0, n);
			give_verdict();
		end
	endtask : tmo

	// One bus cycle; write when w, else read into rdw
	task automatic bus(input bit w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		axiIn.awaddr <= {idx, 2'h0};
		axiIn.araddr <= {idx, 2'h0};
		axiIn.wdata <= {24'h0, d};
		axiIn.wstrb <= 4'hF;
		{axiIn.awvalid, axiIn.wvalid, axiIn.bready} <= {3{w}};
		{axiIn.arvalid, axiIn.rready} <= {2{!w}};
		do begin
			@(posedge core_clk);
			n++;
			if (axiOut.awready) axiIn.awvalid <= 1'b0;
			if (axiOut.wready) axiIn.wvalid <= 1'b0;
			if (axiOut.arready) axiIn.arvalid <= 1'b0;
		end while (!(w ? axiOut.bvalid : axiOut.rvalid) && n < 60);
		rsp = w ? axiOut.bresp : axiOut.rresp;
		rdw = axiOut.rdata;
		{axiIn.bready, axiIn.rready} <= 2'h0;
		tmo(n);
	endtask : bus

	task automatic mask(input logic [2:0] v);
		@(posedge core_clk);
		maskIn <= v;
		maskSet <= 1'b1;
		@(posedge core_clk);
		maskSet <= 1'b0;
	endtask : mask

	// Wait for the next taken service and compare it
	task automatic exp_svc(input logic transfer_controller, input logic [4:0] src, input logic [2:0] lvl);
		int n;
		n = 0;
		while (svcCount === seenCnt && n < 60) begin
			@(posedge core_clk);
			n++;
		end
		tmo(n);
		seenCnt = svcCount;
		chk("source", src, lastSvc.source);
		chk("level", lvl, lastSvc.level);
		chk("vector", maxModeSel ? VT[src] * 2 : VT[src], lastSvc.vector);
		chk("route", transfer_controller, lastDtc);
		chk("trace clear", !transfer_controller, traceClear);
	endtask : exp_svc

	// Absence window; nothing may be taken meanwhile
	task automatic no_svc();
		repeat (16) @(posedge core_clk);
		chk("service count", seenCnt, svcCount);
	endtask : no_svc

	////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hC1BE2B1D;
		{nrst, maxModeSel, slow, maskSet, intReq} <= '0;
		{extReqZeroN, nonmaskPin, extReqN, maskIn} <= 10'h3F8;
		axiIn <= '0;
		fails = 0;
		samples_checked = 0;
		seenCnt = 8'h00;
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		for (int r = 0; r < 6; r++) begin
			bus(0, r[5:0], 8'h00);
			chk("reset value", 32'h0, rdw);
		end
		intReq <= '1;
		no_svc();
		intReq <= '0;
		bus(1, 6'h01, 8'hFF);
		chk("write resp", pic_pkg::RESP_OKAY, rsp);
		bus(1, 6'h07, 8'h00);
		chk("unmapped write", pic_pkg::RESP_SLVERR, rsp);
		bus(0, 6'h01, 8'h00);
		chk("reserved bits", 32'h77, rdw);
		bus(0, 6'h07, 8'h00);
		chk("unmapped read", pic_pkg::RESP_SLVERR, rsp);
		$display("test registers done");
		// Ties within and across modules, level before order
		for (int r = 2; r < 5; r++) bus(1, r[5:0], 8'h33);
		bus(1, 6'h05, 8'h50);
		for (int c = 0; c < 4; c++) begin
			intReq <= TQ[c];
			exp_svc(0, TS[c], TL[c]);
			intReq <= '0;
			mask(3'h0);
		end
		bus(1, 6'h0A, 8'h01);
		intReq <= 23'h000002;
		exp_svc(1, 5'h07, 3'h3);
		intReq <= '0;
		no_svc();
		bus(1, 6'h0A, 8'h00);
		$display("test order done");
		// Random sources, levels, masks and vector modes
		for (int t = 0; t < 40; t++) begin
			i = {$random(seed)} % 23;
			l = 3'($random(seed));
			m = 3'($random(seed));
			maxModeSel <= 1'($random(seed));
			slow <= 1'($random(seed));
			for (int r = 0; r < 6; r++) bus(1, r[5:0], {1'b0, l, 1'b0, l});
			mask(m);
			intReq <= 23'h1 << i;
			if (l > m) begin
				exp_svc(0, i == 0 ? 5'h01 : 5'(i + 6), l);
				repeat (3) @(posedge core_clk);
				chk("mask level", l, cpuMaskLevel);
			end else begin
				no_svc();
			end
			intReq <= '0;
		end
		$display("test random done");
		// Level request zero, gated by its enable
		mask(3'h0);
		bus(1, 6'h00, 8'h60);
		bus(1, 6'h10, 8'h00);
		extReqZeroN <= 1'b0;
		no_svc();
		bus(1, 6'h10, 8'h20);
		exp_svc(0, 5'h00, 3'h6);
		extReqZeroN <= 1'b1;
		// Edge requests one to five, latched, one routed to transfer
		bus(1, 6'h00, 8'h05);
		bus(1, 6'h01, 8'h55);
		bus(1, 6'h08, 8'h01);
		bus(1, 6'h10, 8'h40);
		bus(1, 6'h11, 8'h0F);
		for (int k = 0; k < 5; k++) begin
			mask(3'h0);
			extReqN[k] <= 1'b0;
			exp_svc(k == 0, 5'(k + 2), 3'h5);
			if (k > 0) begin
				extReqN[k] <= 1'b1;
				repeat (4) @(posedge core_clk);
				extReqN[k] <= 1'b0;
				no_svc();
				bus(0, pic_pkg::IDX_STATUS, 8'h00);
				chk("pending latch", 32'h1 << k, rdw);
				mask(3'h0);
				exp_svc(0, 5'(k + 2), 3'h5);
			end
			mask(3'h0);
			no_svc();
			extReqN[k] <= 1'b1;
		end
		bus(1, 6'h11, 8'h00);
		extReqN[2] <= 1'b0;
		no_svc();
		extReqN[2] <= 1'b1;
		$display("test pins done");
		// Nonmask edge select: rising only
		bus(1, 6'h10, 8'h10);
		nonmaskPin <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk("nonmask falling", 32'h0, nmiCount);
		nonmaskPin <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("nonmask rising", 32'h1, nmiCount);
		$display("test nonmask done");
		give_verdict();
	end
endmodule : prioritized_interrupt_controller_tb_top
`default_nettype wire
